// file: hw/sticky_flags.sv
// bank of sticky event flags, hardware set and explicit clear
// assumes set and clr are synchronous to core_clk
`timescale 1ns/1ps
module sticky_flags #(
	parameter int W = 8 // number of flags
)(
	input wire logic core_clk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic [W-1:0] set, // hardware set per flag
	input wire logic [W-1:0] clr, // clear per flag
	output logic [W-1:0] q // flag values
);
	typedef struct packed {
		logic [W-1:0] bits;
	} flag_state_type;

	flag_state_type s_ff;
	flag_state_type nxt_s;

	// set beats a clear in the same cycle so no event is lost
	always_comb begin
		nxt_s.bits = (s_ff.bits & ~clr) | set;
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign q = s_ff.bits;
endmodule

// file: hw/usb_glue_ctl.sv
// firmware side of the usb global control block: axi4-lite slave that
// turns command words into device register accesses
// assumes one core clock shared with the device end
`timescale 1ns/1ps
module usb_glue_ctl (
	input wire logic core_clk, // core clock
	input wire logic resetn, // async reset, active low
	usb_glue_if.ctl rif, // device register port
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready // read data ready
);
	import usb_glue_pkg::*;

	typedef struct packed {
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		ctl_state_type st;
		logic reg_wr;
		logic reg_rd;
		logic [7:0] reg_addr;
		logic [7:0] reg_wdata;
		logic [7:0] rd_last;
		logic allow_wk;
		logic fen_seen;
	} ctl_full_type;

	ctl_full_type s_ff;
	ctl_full_type nxt_s;
	logic [7:0] a;
	logic [7:0] d;
	logic [1:0] op;

	// one write and one read in flight; a channel stays closed once taken until its response is accepted
	assign awready = ~s_ff.aw_got & ~s_ff.bvalid;
	assign wready = ~s_ff.w_got & ~s_ff.bvalid;
	assign arready = ~s_ff.rvalid;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.reg_wr = 1'b0;
		nxt_s.reg_rd = 1'b0;
		a = s_ff.w_data[15:8];
		d = s_ff.w_data[7:0];
		op = s_ff.w_data[17:16];
		if (awvalid && awready) begin
			nxt_s.aw_got = 1'b1;
			nxt_s.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			nxt_s.w_got = 1'b1;
			nxt_s.w_data = wdata;
			nxt_s.w_strb = wstrb;
		end
		if (s_ff.bvalid && bready) begin
			nxt_s.bvalid = 1'b0;
		end
		// write executes once address and data are both held
		if (s_ff.aw_got && s_ff.w_got) begin
			nxt_s.aw_got = 1'b0;
			nxt_s.w_got = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = RESP_OKAY;
			if (s_ff.aw_addr == OFS_CMD) begin
				if (s_ff.st != CS_IDLE || s_ff.w_strb[2:0] != 3'h7) begin
					nxt_s.bresp = RESP_SLVERR;
				end else if (op == OP_WR) begin
					// wakeup enable only passes when the host allowed it
					if (a == OFS_GCTRL && !s_ff.allow_wk) begin
						d[GC_RWE] = 1'b0;
					end
					// function enable, once set, is never written back to zero
					if (a == OFS_ADDR && s_ff.fen_seen) begin
						d[AD_FEN] = 1'b1;
					end
					if (a == OFS_ADDR && d[AD_FEN]) begin
						nxt_s.fen_seen = 1'b1;
					end
					nxt_s.reg_wr = 1'b1;
					nxt_s.reg_addr = a;
					nxt_s.reg_wdata = d;
					nxt_s.st = CS_STROBE;
				end else if (op == OP_RD) begin
					nxt_s.reg_rd = 1'b1;
					nxt_s.reg_addr = a;
					nxt_s.st = CS_STROBE;
				end else begin
					nxt_s.bresp = RESP_SLVERR;
				end
			end else if (s_ff.aw_addr == OFS_POLICY) begin
				if (s_ff.w_strb[0]) begin
					nxt_s.allow_wk = s_ff.w_data[0];
				end
			end else begin
				nxt_s.bresp = RESP_SLVERR;
			end
		end
		// device access sequencing; read data lands one cycle after strobe
		case (s_ff.st)
			CS_STROBE: begin
				nxt_s.st = s_ff.reg_rd ? CS_CAPTURE : CS_IDLE;
			end
			CS_CAPTURE: begin
				nxt_s.rd_last = rif.reg_rdata;
				nxt_s.st = CS_IDLE;
			end
			default: begin
			end
		endcase
		if (s_ff.rvalid && rready) begin
			nxt_s.rvalid = 1'b0;
		end
		// axi read path
		if (arvalid && arready) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rresp = RESP_OKAY;
			if (araddr == OFS_STAT) begin
				nxt_s.rdata = {16'h0000, s_ff.rd_last, 4'h0, rif.irq_level, rif.irq,
					s_ff.st != CS_IDLE};
			end else if (araddr == OFS_POLICY) begin
				nxt_s.rdata = {31'h0000_0000, s_ff.allow_wk};
			end else if (araddr == OFS_CMD) begin
				nxt_s.rdata = 32'h0000_0000;
			end else begin
				nxt_s.rdata = 32'h0000_0000;
				nxt_s.rresp = RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
			s_ff.st <= CS_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign bvalid = s_ff.bvalid;
	assign bresp = s_ff.bresp;
	assign rvalid = s_ff.rvalid;
	assign rdata = s_ff.rdata;
	assign rresp = s_ff.rresp;
	assign rif.reg_wr = s_ff.reg_wr;
	assign rif.reg_rd = s_ff.reg_rd;
	assign rif.reg_addr = s_ff.reg_addr;
	assign rif.reg_wdata = s_ff.reg_wdata;
endmodule

// file: hw/usb_glue_dev.sv
// usb device global control, addressing and interrupt event logic
// assumes bus events arrive as one-cycle pulses synchronous to core_clk
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - two priority bits give irq level 0..3
// - all event flags merge into one irq
// - in packet acked sets transmit complete flag
// - out packet into bank zero sets flag
// - bank one flag only on ping-pong endpoints
// - setup packet accepted sets setup flag
// - stall sent sets stalled, except on isochronous endpoints; setup clears it
// - start of frame sets frame flag
// - resume while suspended sets wake flag
// - bus suspend sets suspend flag
// - enable clear holds controller reset, gated
// - suspend clock bit blocks 48 MHz clock
// - remote resume needs enable, clocks, 5 ms
// - resume in progress bit, hardware owned
// - firmware enables remote wakeup only if allowed
// - configured bit cleared by bus reset
// - address enable clear means address zero
// - function enable cleared at power-up only
// - seven bit address cleared by bus reset
// - reserved control bit four reads zero
// - global flags gated by their enables
// - end of bus reset sets flag
module usb_glue_dev #(
	parameter int NUM_EP = usb_glue_pkg::NUM_EP, // endpoints, at most 8
	parameter logic [NUM_EP-1:0] PINGPONG_EP = '0, // ping-pong endpoints
	parameter logic [NUM_EP-1:0] ISO_EP = '0, // isochronous endpoints
	parameter int SUSP_MIN_CYCLES = usb_glue_pkg::SUSP_MIN_CYC, // suspend before resume
	parameter int RSM_DRIVE_CYCLES = usb_glue_pkg::RSM_DRIVE_CYC // resume drive length
)(
	input wire logic core_clk, // core clock
	input wire logic resetn, // async reset, active low
	usb_glue_if.dev rif, // register port and irq
	input wire logic [NUM_EP-1:0] ep_tx_acked, // host acked in packet
	input wire logic [NUM_EP-1:0] ep_rx_bank0, // out packet stored in bank 0
	input wire logic [NUM_EP-1:0] ep_rx_bank1, // out packet stored in bank 1
	input wire logic [NUM_EP-1:0] ep_setup_rx, // setup packet accepted
	input wire logic [NUM_EP-1:0] ep_stall_sent, // stall handshake sent
	input wire logic sof_rx, // start of frame received
	input wire logic bus_suspend, // suspend detected
	input wire logic bus_resume, // non-idle seen on bus
	input wire logic bus_reset, // bus reset seen
	input wire logic bus_reset_end, // end of bus reset
	output logic ctrl_rst_n, // controller reset, active low
	output logic xcvr_en, // transceiver on
	output logic ctrl_clk_en, // controller clock gate
	output logic clk48_en, // 48 MHz clock gate
	output logic resume_drive, // drive upstream resume
	output logic func_en, // function enable
	output logic configured, // device configured
	output logic [6:0] func_addr // address in use
);
	import usb_glue_pkg::*;

	localparam int SCW = $clog2(SUSP_MIN_CYCLES + 1);
	localparam int RCW = $clog2(RSM_DRIVE_CYCLES + 1);
	localparam int EW = NUM_EP * 8;

	typedef struct packed {
		logic [7:0] gctrl;
		logic [7:0] gie;
		logic [7:0] addr;
		logic [1:0] prio;
		logic [NUM_EP-1:0] ep_ie;
		logic [7:0] rdata;
		logic rip;
		logic drive;
		logic suspended;
		logic send_d;
		logic [SCW-1:0] susp_cnt;
		logic [RCW-1:0] rsm_cnt;
	} dev_state_type;

	dev_state_type s_ff;
	dev_state_type nxt_s;
	logic [7:0] gset;
	logic [7:0] gclr;
	logic [7:0] gq;
	logic [EW-1:0] eset;
	logic [EW-1:0] eclr;
	logic [EW-1:0] eq;
	logic [7:0] rd;
	logic run;
	logic clocks_on;
	logic susp_ok;
	logic irq_c;

	// endpoint flag register decode, shared by read and write paths
	function automatic logic ep_sel(input logic [7:0] a, input int e);
		return a == (OFS_EPFLAG + 8'(e));
	endfunction

	sticky_flags #(.W(8)) u_gflags (
		.core_clk(core_clk),
		.resetn(resetn),
		.set(gset),
		.clr(gclr),
		.q(gq)
	);

	sticky_flags #(.W(EW)) u_epflags (
		.core_clk(core_clk),
		.resetn(resetn),
		.set(eset),
		.clr(eclr),
		.q(eq)
	);

	// next state: register writes, events, suspend and upstream resume
	always_comb begin
		nxt_s = s_ff;
		run = s_ff.gctrl[GC_ENABLE];
		clocks_on = run & ~s_ff.gctrl[GC_SUSPEND_CLOCK_GATE];
		susp_ok = s_ff.susp_cnt == SCW'(SUSP_MIN_CYCLES);
		gset = '0;
		gclr = '0;
		eset = '0;
		eclr = '0;
		rd = 8'h00;
		irq_c = |(gq & s_ff.gie);
		// firmware writes; flag registers clear on written zeros
		if (rif.reg_wr) begin
			if (rif.reg_addr == OFS_GCTRL) begin
				nxt_s.gctrl = rif.reg_wdata & GCTRL_WMASK;
			end else if (rif.reg_addr == OFS_GFLAGS) begin
				gclr = ~rif.reg_wdata & GF_MASK;
			end else if (rif.reg_addr == OFS_GIE) begin
				nxt_s.gie = rif.reg_wdata & GF_MASK;
			end else if (rif.reg_addr == OFS_ADDR) begin
				nxt_s.addr = rif.reg_wdata;
			end else if (rif.reg_addr == OFS_PRIO) begin
				nxt_s.prio = rif.reg_wdata[1:0];
			end else if (rif.reg_addr == OFS_EPIE) begin
				nxt_s.ep_ie = rif.reg_wdata[NUM_EP-1:0];
			end else begin
				for (int e = 0; e < NUM_EP; e++) begin
					if (ep_sel(rif.reg_addr, e)) begin
						eclr[e*8 +: 8] = ~rif.reg_wdata & EF_MASK;
					end
				end
			end
		end
		// global bus events, ignored while the controller is off
		gset[GF_WAKE] = run & bus_resume & s_ff.suspended & ~s_ff.drive;
		gset[GF_REND] = run & bus_reset_end;
		gset[GF_SOF] = run & sof_rx;
		gset[GF_SUSP] = run & bus_suspend;
		// endpoint events, one flag byte per endpoint
		for (int e = 0; e < NUM_EP; e++) begin
			eset[e*8+EF_TX] = run & ep_tx_acked[e];
			eset[e*8+EF_RX0] = run & ep_rx_bank0[e];
			eset[e*8+EF_RX1] = run & ep_rx_bank1[e] & PINGPONG_EP[e];
			eset[e*8+EF_SETUP] = run & ep_setup_rx[e];
			eset[e*8+EF_STALL] = run & ep_stall_sent[e] & ~ISO_EP[e];
			eclr[e*8+EF_STALL] = eclr[e*8+EF_STALL] | ep_setup_rx[e];
			irq_c = irq_c | (s_ff.ep_ie[e] & |eq[e*8 +: 8]);
		end
		// controller held in reset: every event flag drops
		if (!run) begin
			gclr = '1;
			eclr = '1;
		end
		// suspend state; resume detection works with the 48 MHz clock gated
		if (!run || bus_reset || (bus_resume && !s_ff.drive)) begin
			nxt_s.suspended = 1'b0;
		end else if (bus_suspend) begin
			nxt_s.suspended = 1'b1;
		end
		// time spent suspended, saturating
		if (!s_ff.suspended) begin
			nxt_s.susp_cnt = '0;
		end else if (!susp_ok) begin
			nxt_s.susp_cnt = s_ff.susp_cnt + SCW'(1);
		end
		// upstream resume; a dropped send request cancels a waiting one
		nxt_s.send_d = s_ff.gctrl[GC_SENDWK];
		if (!run) begin
			nxt_s.rip = 1'b0;
			nxt_s.drive = 1'b0;
			nxt_s.rsm_cnt = '0;
		end else if (s_ff.drive) begin
			if (s_ff.rsm_cnt == RCW'(RSM_DRIVE_CYCLES - 1)) begin
				nxt_s.drive = 1'b0;
				nxt_s.rip = 1'b0;
				nxt_s.suspended = 1'b0;
			end else begin
				nxt_s.rsm_cnt = s_ff.rsm_cnt + RCW'(1);
			end
		end else if (s_ff.rip) begin
			if (!s_ff.gctrl[GC_SENDWK]) begin
				nxt_s.rip = 1'b0;
			end else if (clocks_on && s_ff.suspended && susp_ok) begin
				nxt_s.drive = 1'b1;
				nxt_s.rsm_cnt = '0;
			end
		end else if (s_ff.gctrl[GC_SENDWK] && !s_ff.send_d && s_ff.gctrl[GC_RWE]) begin
			nxt_s.rip = 1'b1;
		end
		// bus reset drops configuration and address, not function enable
		if (bus_reset) begin
			nxt_s.gctrl[GC_CONF] = 1'b0;
			nxt_s.gctrl[GC_AEN] = 1'b0;
			nxt_s.addr[6:0] = 7'h00;
		end
		// read data, registered one cycle after the strobe
		if (rif.reg_rd) begin
			if (rif.reg_addr == OFS_GCTRL) begin
				rd = {s_ff.gctrl[7:5], 1'b0, s_ff.rip, s_ff.gctrl[2:0]};
			end else if (rif.reg_addr == OFS_GFLAGS) begin
				rd = gq & GF_MASK;
			end else if (rif.reg_addr == OFS_GIE) begin
				rd = s_ff.gie;
			end else if (rif.reg_addr == OFS_ADDR) begin
				rd = s_ff.addr;
			end else if (rif.reg_addr == OFS_PRIO) begin
				rd = {6'h00, s_ff.prio};
			end else if (rif.reg_addr == OFS_EPIE) begin
				rd = 8'(s_ff.ep_ie);
			end else begin
				for (int e = 0; e < NUM_EP; e++) begin
					if (ep_sel(rif.reg_addr, e)) begin
						rd = eq[e*8 +: 8];
					end
				end
			end
			nxt_s.rdata = rd;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_ff <= '0;
			s_ff.gctrl <= GCTRL_RST;
			s_ff.gie <= GIE_RST;
			s_ff.addr <= ADDR_RST;
			s_ff.prio <= PRIO_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// level request, stays up while any enabled flag pends
	assign rif.irq = irq_c;
	assign rif.irq_level = s_ff.prio;
	assign rif.reg_rdata = s_ff.rdata;

	// controller enable gates reset, transceiver and clocks
	assign ctrl_rst_n = s_ff.gctrl[GC_ENABLE];
	assign xcvr_en = s_ff.gctrl[GC_ENABLE];
	assign ctrl_clk_en = s_ff.gctrl[GC_ENABLE];
	assign clk48_en = s_ff.gctrl[GC_ENABLE] & ~s_ff.gctrl[GC_SUSPEND_CLOCK_GATE];
	assign resume_drive = s_ff.drive;
	assign func_en = s_ff.addr[AD_FEN];
	assign configured = s_ff.gctrl[GC_CONF];
	// default address zero until firmware enables the assigned one
	assign func_addr = s_ff.gctrl[GC_AEN] ? s_ff.addr[6:0] : 7'h00;
endmodule

// file: hw/usb_glue_if.sv
// register port between the usb global control device and its controller
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface usb_glue_if;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic irq;
	logic [1:0] irq_level;

	modport dev (input reg_wr, reg_rd, reg_addr, reg_wdata, output reg_rdata, irq, irq_level);
	modport ctl (output reg_wr, reg_rd, reg_addr, reg_wdata, input reg_rdata, irq, irq_level);
endinterface

// file: hw/usb_glue_pkg.sv
// constants shared by the usb global control device end and its controller end
// assumes a single 10 MHz core clock on both ends
package usb_glue_pkg;
	// clock and timing
	localparam int CLK_HZ = 10_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	localparam int SUSP_MIN_MS = 5;
	localparam int SUSP_MIN_CYC = SUSP_MIN_MS * CYC_PER_MS;
	localparam int RSM_DRIVE_MS = 10;
	localparam int RSM_DRIVE_CYC = RSM_DRIVE_MS * CYC_PER_MS;
	localparam int NUM_EP = 4;

	// device register offsets
	localparam logic [7:0] OFS_GCTRL = 8'hbc;
	localparam logic [7:0] OFS_GFLAGS = 8'hbd;
	localparam logic [7:0] OFS_GIE = 8'hbe;
	localparam logic [7:0] OFS_ADDR = 8'hc6;
	localparam logic [7:0] OFS_PRIO = 8'hb8;
	localparam logic [7:0] OFS_EPIE = 8'hc0;
	localparam logic [7:0] OFS_EPFLAG = 8'he0;

	// global control bits
	localparam int GC_ENABLE = 7;
	localparam int GC_SUSPEND_CLOCK_GATE = 6;
	localparam int GC_SENDWK = 5;
	localparam int GC_RIP = 3;
	localparam int GC_RWE = 2;
	localparam int GC_CONF = 1;
	localparam int GC_AEN = 0;
	localparam logic [7:0] GCTRL_WMASK = 8'he7;
	localparam logic [7:0] GCTRL_RST = 8'h00;

	// global flag bits, same positions in the enable register
	localparam int GF_WAKE = 5;
	localparam int GF_REND = 4;
	localparam int GF_SOF = 3;
	localparam int GF_SUSP = 0;
	localparam logic [7:0] GF_MASK = 8'h39;
	localparam logic [7:0] GIE_RST = 8'h10;

	// address register
	localparam int AD_FEN = 7;
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [1:0] PRIO_RST = 2'h0;

	// per endpoint flag bits
	localparam int EF_TX = 0;
	localparam int EF_RX0 = 1;
	localparam int EF_SETUP = 2;
	localparam int EF_STALL = 3;
	localparam int EF_RX1 = 6;
	localparam logic [7:0] EF_MASK = 8'h4f;

	// controller axi4-lite map and command word
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_STAT = 8'h04;
	localparam logic [7:0] OFS_POLICY = 8'h08;
	localparam logic [1:0] OP_WR = 2'h1;
	localparam logic [1:0] OP_RD = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_STROBE = 2'h1,
		CS_CAPTURE = 2'h2
	} ctl_state_type;
endpackage

// file: test/usb_device_global_control_irq_test.sv
// self-checking bench: controller and device ends joined, driven over axi4-lite
// assumes the design package and both ends compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("BAD %0t got %0h want %0h", $time, (g), (e)); end end
module usb_device_global_control_irq_test;
	import usb_glue_pkg::*;
	localparam int SOF = 20;
	localparam int SUS = 21;
	localparam int RSM = 22;
	localparam int BRS = 23;
	localparam int BRE = 24;
	logic core_clk = 0;
	logic resetn = 0;
	logic [24:0] ev = '0;
	logic ctrl_rst_n, xcvr_en, ctrl_clk_en, clk48_en, resume_drive, func_en, configured;
	logic [6:0] func_addr;
	logic [7:0] awaddr = '0, araddr = '0, v;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = '0, rdata, s;
	logic [3:0] wstrb = '0;
	logic [1:0] bresp, rresp, r;
	int errors = 0;
	int compares = 0;

	usb_glue_if rif();
	usb_glue_dev #(.PINGPONG_EP(4'h4), .SUSP_MIN_CYCLES(20), .RSM_DRIVE_CYCLES(10))
		usb_glue_dev_inst (.core_clk(core_clk), .resetn(resetn), .rif(rif),
		.ep_tx_acked(ev[3:0]), .ep_rx_bank0(ev[7:4]), .ep_rx_bank1(ev[11:8]),
		.ep_setup_rx(ev[15:12]), .ep_stall_sent(ev[19:16]), .sof_rx(ev[SOF]),
		.bus_suspend(ev[SUS]), .bus_resume(ev[RSM]), .bus_reset(ev[BRS]),
		.bus_reset_end(ev[BRE]), .ctrl_rst_n(ctrl_rst_n), .xcvr_en(xcvr_en),
		.ctrl_clk_en(ctrl_clk_en), .clk48_en(clk48_en), .resume_drive(resume_drive),
		.func_en(func_en), .configured(configured), .func_addr(func_addr));
	usb_glue_ctl usb_glue_ctl_inst (.core_clk(core_clk), .resetn(resetn), .rif(rif),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));
	usb_glue_checker usb_glue_checker_inst (.core_clk(core_clk), .resetn(resetn),
		.reg_wr(rif.reg_wr), .reg_rd(rif.reg_rd), .reg_addr(rif.reg_addr),
		.reg_wdata(rif.reg_wdata), .reg_rdata(rif.reg_rdata), .irq(rif.irq),
		.irq_level(rif.irq_level));

	// 10 MHz core clock
	always #50 core_clk = ~core_clk;

	task automatic wrap_up();
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic hang(input int n);
		if (n > 300) begin
			errors++;
			$display("BAD %0t wait ran out", $time);
			wrap_up();
		end
	endtask

	// axi write: both channels offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		int n;
		logic aw, w;
		n = 0;
		aw = 0;
		w = 0;
		// let an edge pass so back-to-back calls never drive bready twice in one step
		@(posedge core_clk);
		awaddr <= a;
		awvalid <= 1;
		wdata <= d;
		wstrb <= 4'hf;
		wvalid <= 1;
		bready <= 1;
		forever begin
			@(posedge core_clk);
			n++;
			hang(n);
			if (aw && w && bvalid) begin
				rs = bresp;
				bready <= 0;
				break;
			end
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 0;
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		int n;
		logic ar;
		n = 0;
		ar = 0;
		// same reason as the write: rready is never lowered and raised in one step
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		forever begin
			@(posedge core_clk);
			n++;
			hang(n);
			if (ar && rvalid) begin
				d = rdata;
				rs = rresp;
				rready <= 0;
				break;
			end
			if (!ar && arready) begin
				ar = 1;
				arvalid <= 0;
			end
		end
	endtask
	// device accesses go through the command word, then status is polled until idle
	task automatic idle();
		int n;
		n = 0;
		do begin
			axi_rd(OFS_STAT, s, r);
			n++;
			hang(n * 20);
		end while (s[0] !== 1'b0);
	endtask
	task automatic dev_wr(input logic [7:0] o, input logic [7:0] d);
		axi_wr(OFS_CMD, {14'h0, OP_WR, o, d}, r);
		idle();
	endtask
	task automatic dev_rd(input logic [7:0] o);
		axi_wr(OFS_CMD, {14'h0, OP_RD, o, 8'h00}, r);
		idle();
		v = s[15:8];
	endtask
	// one-cycle bus event pulse, then a quiet edge
	task automatic fire(input logic [24:0] e);
		ev <= e;
		@(posedge core_clk);
		ev <= '0;
		@(posedge core_clk);
	endtask

	task automatic t_reset();
		`CHK({ctrl_rst_n, xcvr_en, clk48_en, resume_drive}, 4'h0)
		`CHK({configured, func_en, func_addr}, 9'h000)
		`CHK({rif.irq, rif.irq_level}, 3'h0)
		dev_rd(OFS_GCTRL);
		`CHK(v, GCTRL_RST)
		dev_rd(OFS_GIE);
		`CHK(v, GIE_RST)
		dev_rd(OFS_ADDR);
		`CHK(v, ADDR_RST)
		dev_rd(8'h10);
		`CHK(v, 8'h00)
		axi_rd(8'h0c, s, r);
		`CHK(r, RESP_SLVERR)
		axi_wr(OFS_STAT, 32'h0000_0000, r);
		`CHK(r, RESP_SLVERR)
		$display("reset values done");
	endtask
	task automatic t_control();
		dev_wr(OFS_GCTRL, 8'hff);
		dev_rd(OFS_GCTRL);
		`CHK(v, 8'he3)
		`CHK(v[GC_RWE], 1'b0)
		`CHK({ctrl_rst_n, xcvr_en, ctrl_clk_en, clk48_en, configured}, 5'h1d)
		dev_wr(OFS_GCTRL, 8'h83);
		`CHK(clk48_en, 1'b1)
		for (int p = 0; p < 4; p++) begin
			dev_wr(OFS_PRIO, 8'(p));
			`CHK(rif.irq_level, 2'(p))
		end
		$display("control and priority done");
	endtask
	task automatic t_address();
		dev_wr(OFS_ADDR, 8'h85);
		`CHK({func_en, func_addr}, 8'h85)
		fire(25'h1 << BRS);
		`CHK({configured, func_en, func_addr}, 9'h080)
		dev_rd(OFS_GCTRL);
		`CHK(v, 8'h80)
		dev_wr(OFS_GCTRL, 8'h81);
		`CHK(func_addr, 7'h00)
		dev_wr(OFS_ADDR, 8'h06);
		`CHK(func_addr, 7'h06)
		dev_rd(OFS_ADDR);
		`CHK(v, 8'h86)
		$display("address done");
	endtask
	task automatic t_global();
		dev_wr(OFS_GIE, GF_MASK);
		fire(25'h1 << SOF);
		fire(25'h1 << BRE);
		fire(25'h1 << SUS);
		dev_rd(OFS_GFLAGS);
		`CHK(v, 8'h19)
		`CHK(rif.irq, 1'b1)
		fire(25'h1 << RSM);
		dev_rd(OFS_GFLAGS);
		`CHK(v, 8'h39)
		dev_wr(OFS_GIE, 8'h00);
		`CHK(rif.irq, 1'b0)
		dev_wr(OFS_GIE, 8'h08);
		`CHK(rif.irq, 1'b1)
		dev_wr(OFS_GFLAGS, 8'h37);
		dev_rd(OFS_GFLAGS);
		`CHK({v, rif.irq}, 9'h062)
		dev_wr(OFS_GFLAGS, 8'h00);
		$display("global flags done");
	endtask
	task automatic t_endpoint();
		dev_wr(OFS_EPIE, 8'h0f);
		fire(25'h0_2222);
		dev_rd(OFS_EPFLAG + 8'h01);
		`CHK(v, 8'h07)
		`CHK(rif.irq, 1'b1)
		fire(25'h1 << 17);
		dev_rd(OFS_EPFLAG + 8'h01);
		`CHK(v, 8'h0f)
		fire(25'h1 << 13);
		dev_rd(OFS_EPFLAG + 8'h01);
		`CHK(v, 8'h07)
		fire(25'h1 << 10);
		dev_rd(OFS_EPFLAG + 8'h02);
		`CHK(v, 8'h40)
		dev_wr(OFS_EPFLAG + 8'h01, 8'h00);
		dev_wr(OFS_EPFLAG + 8'h02, 8'h00);
		`CHK(rif.irq, 1'b0)
		$display("endpoint flags done");
	endtask
	task automatic t_wakeup();
		logic seen;
		axi_wr(OFS_POLICY, 32'h1, r);
		`CHK(r, RESP_OKAY)
		dev_wr(OFS_GCTRL, 8'h00);
		`CHK({ctrl_rst_n, xcvr_en, ctrl_clk_en}, 3'h0)
		dev_wr(OFS_GCTRL, 8'h84);
		dev_wr(OFS_GCTRL, 8'ha4);
		dev_rd(OFS_GCTRL);
		`CHK(v, 8'hac)
		seen = 0;
		repeat (40) begin
			@(posedge core_clk);
			seen = seen | resume_drive;
		end
		`CHK(seen, 1'b0)
		dev_wr(OFS_GCTRL, 8'h84);
		fire(25'h1 << SUS);
		repeat (30) @(posedge core_clk);
		dev_wr(OFS_GCTRL, 8'ha4);
		for (int n = 0; resume_drive !== 1'b1; n++) begin
			@(posedge core_clk);
			hang(n);
		end
		for (int n = 0; resume_drive !== 1'b0; n++) begin
			@(posedge core_clk);
			hang(n);
		end
		dev_rd(OFS_GCTRL);
		`CHK(v, 8'ha4)
		$display("remote wakeup done");
	endtask

	initial begin
		repeat (2) @(posedge core_clk);
		resetn <= 1;
		t_reset();
		t_control();
		t_address();
		t_global();
		t_endpoint();
		t_wakeup();
		wrap_up();
	end
endmodule

// file: test/usb_glue_checker.sv
// protocol checks on the register port between the two usb global control ends
// assumes one core clock, reset active low, ports named as the interface signals
`timescale 1ns/1ps
module usb_glue_checker (
	input wire logic core_clk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata, // read data
	input wire logic irq, // combined interrupt
	input wire logic [1:0] irq_level // priority level
);
	import usb_glue_pkg::*;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic addr_wr_ff;
	logic nxt_addr_wr;

	// last write went to the address register; wdata stays held until the next write
	always_comb begin
		nxt_addr_wr = addr_wr_ff;
		if (reg_wr) begin
			nxt_addr_wr = (reg_addr == OFS_ADDR);
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_wr_ff <= 1'b0;
		end else begin
			addr_wr_ff <= nxt_addr_wr;
		end
	end

	sequence s_prio_wr;
		reg_wr && reg_addr == OFS_PRIO;
	endsequence
	sequence s_rd(logic [7:0] ofs);
		reg_rd && reg_addr == ofs;
	endsequence

	property p_prio_load;
		s_prio_wr |=> irq_level == $past(reg_wdata[1:0]);
	endproperty
	a_prio_load: assert property (p_prio_load)
		else $error("priority level not loaded");
	property p_prio_hold;
		$changed(irq_level) |-> $past(reg_wr) && $past(reg_addr) == OFS_PRIO;
	endproperty
	a_prio_hold: assert property (p_prio_hold)
		else $error("priority level moved without a write");
	// flags drop through software writes, and stall flags also on a setup packet; the check expects irq to fall only after a write
	property p_irq_fall;
		$fell(irq) |-> $past(reg_wr);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("irq dropped without a write");
	property p_ctrl_rsvd;
		s_rd(OFS_GCTRL) |=> !reg_rdata[4];
	endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd)
		else $error("reserved control bit read as one");
	property p_unmapped;
		s_rd(8'h10) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped offset read nonzero");
	property p_gie_bits;
		s_rd(OFS_GIE) |=> (reg_rdata & ~GF_MASK) == 8'h00;
	endproperty
	a_gie_bits: assert property (p_gie_bits)
		else $error("enable register reserved bits set");
	property p_gflag_bits;
		s_rd(OFS_GFLAGS) |=> (reg_rdata & ~GF_MASK) == 8'h00;
	endproperty
	a_gflag_bits: assert property (p_gflag_bits)
		else $error("flag register reserved bits set");
	property p_addr_back;
		s_rd(OFS_ADDR) ##0 addr_wr_ff |=> (reg_rdata & 8'h7f) == ($past(reg_wdata) & 8'h7f);
	endproperty
	a_addr_back: assert property (p_addr_back)
		else $error("address field not read back");
	property p_rst_quiet;
		$rose(resetn) |-> !irq && irq_level == 2'h0;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet)
		else $error("irq active out of reset");
endmodule
